// ===== hw/rx_len_pkg.sv
// Purpose: constants shared by the receive frame length filter
// Assumes: AHB-Lite word per register, byte address is four times the index
// Notes:   counters and limits keep the widths of the register map
package rx_len_pkg;
    // =========================================================
    // register indices, byte address = index * 4
    localparam logic [9:0] IDX_EVENT       = 10'h1EC;
    localparam logic [9:0] IDX_MASK        = 10'h1ED;
    localparam logic [9:0] IDX_LOWER       = 10'h1EF;
    localparam logic [9:0] IDX_UPPER_LOW   = 10'h1F0;
    localparam logic [9:0] IDX_UPPER_HIGH  = 10'h1F1;
    localparam logic [9:0] IDX_SHORT_B0    = 10'h1F4;
    localparam logic [9:0] IDX_SHORT_B1    = 10'h1F5;
    localparam logic [9:0] IDX_SHORT_B2    = 10'h1F6;
    localparam logic [9:0] IDX_SHORT_B3    = 10'h1F7;
    localparam logic [9:0] IDX_LONG_B0     = 10'h1F8;
    localparam logic [9:0] IDX_LONG_B1     = 10'h1F9;
    localparam logic [9:0] IDX_LONG_B2     = 10'h1FA;
    localparam logic [9:0] IDX_LONG_B3     = 10'h1FB;
    // =========================================================
    // field positions and reset values
    localparam int         ENFORCE_BIT     = 7;
    localparam int         EV_SHORT_BIT    = 6;
    localparam int         EV_LONG_BIT     = 5;
    localparam logic [6:0] LOWER_RESET     = 7'h40;
    localparam logic [7:0] UPPER_LOW_RESET = 8'hF2;
    localparam logic [6:0] UPPER_HI_RESET  = 7'h05;
    localparam logic [1:0] EV_MASK_RESET   = 2'h3;
    localparam int         SHORT_CNT_W     = 24;
    localparam int         LONG_CNT_W      = 16;
    localparam int         LEN_W           = 16;
    // =========================================================
    // link nibble codes and bus codes
    localparam logic [3:0] NIB_PREAMBLE    = 4'h5;
    localparam logic [3:0] NIB_SFD         = 4'hD;
    localparam logic [1:0] HTRANS_NONSEQ   = 2'h2;
    localparam logic [1:0] HTRANS_SEQ      = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b001,
        ST_PREAMBLE = 3'b010,
        ST_BODY     = 3'b100
    } rx_state_e;
endpackage

// ===== hw/rx_frame_length_filter.sv
// Purpose: receive frame length check with violation counters and events
// Assumes: MII receive pins are asynchronous and slow next to CLOCK_IN
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
module rx_frame_length_filter
    import rx_len_pkg::*;
(
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RST_IN,
    input  wire logic                   HSEL_IN,
    input  wire logic [31:0]            HADDR_IN,
    input  wire logic [1:0]             HTRANS_IN,
    input  wire logic                   HWRITE_IN,
    input  wire logic [2:0]             HSIZE_IN,
    input  wire logic [31:0]            HWDATA_IN,
    input  wire logic                   HREADY_IN,
    output logic      [31:0]            HRDATA_OUT,
    output logic                        HREADYOUT_OUT,
    output logic                        HRESP_OUT,
    input  wire logic                   RX_CLK_IN,
    input  wire logic                   RX_DV_IN,
    input  wire logic [3:0]             RXD_IN,
    input  wire logic                   BUFFER_ERR_IN,
    output logic                        FRAME_END_OUT,
    output logic                        FRAME_DROP_OUT,
    output logic      [rx_len_pkg::LEN_W-1:0] FRAME_BYTES_OUT,
    output logic                        IRQ_OUT
);
    import rx_len_pkg::*;

    // =========================================================
    // link synchronisers and clock edge finder
    // the link clock is only sampled, never used as a clock, so the whole
    // block stays in one domain
    logic [1:0] clk_sync;
    logic [1:0] dv_sync;
    logic [3:0] d_meta;
    logic [3:0] d_sync;
    logic       clk_prev;
    logic       link_edge;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            clk_sync <= 2'h0;
            dv_sync  <= 2'h0;
            d_meta   <= 4'h0;
            d_sync   <= 4'h0;
            clk_prev <= 1'b0;
        end else begin
            clk_sync <= {clk_sync[0], RX_CLK_IN};
            dv_sync  <= {dv_sync[0], RX_DV_IN};
            d_meta   <= RXD_IN;
            d_sync   <= d_meta;
            clk_prev <= clk_sync[1];
        end
    end

    // data and valid travel the same two stages as the clock, so the
    // sampled values are those the partner set up before its rising edge
    assign link_edge = clk_sync[1] & ~clk_prev;

    // =========================================================
    // control registers
    logic       lower_limit_check_on;
    logic [6:0] lower_limit;
    logic       upper_limit_check_on;
    logic [14:0] upper_limit;
    logic [1:0] ev_mask;
    logic [1:0] ev_status;

    // =========================================================
    // frame tracking
    rx_state_e       state;
    logic            nib_phase;
    logic [LEN_W-1:0] byte_cnt;
    logic            buf_err_seen;
    logic            frame_done;
    logic            is_short;
    logic            is_long;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            state     <= ST_IDLE;
            nib_phase <= 1'b0;
            byte_cnt  <= '0;
        end else if (link_edge) begin
            case (state)
                ST_IDLE: begin
                    nib_phase <= 1'b0;
                    byte_cnt  <= '0;
                    if (dv_sync[1] && d_sync == NIB_PREAMBLE) begin
                        state <= ST_PREAMBLE;
                    end
                end
                ST_PREAMBLE: begin
                    if (!dv_sync[1]) begin
                        state <= ST_IDLE;
                    end else if (d_sync == NIB_SFD) begin
                        state <= ST_BODY;
                    end else if (d_sync != NIB_PREAMBLE) begin
                        state <= ST_IDLE;
                    end
                end
                ST_BODY: begin
                    if (!dv_sync[1]) begin
                        state <= ST_IDLE;
                    end else begin
                        nib_phase <= ~nib_phase;
                        // every byte after the delimiter counts, check sequence too
                        // sticking at all-ones keeps a runaway frame long, never short
                        if (nib_phase && byte_cnt != {LEN_W{1'b1}}) begin
                            byte_cnt <= byte_cnt + 1'b1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    assign frame_done = link_edge && state == ST_BODY && !dv_sync[1];
    // bytes after the delimiter only, preamble and delimiter never reach byte_cnt
    assign is_short = lower_limit_check_on
                   && byte_cnt < {{(LEN_W-7){1'b0}}, lower_limit};
    assign is_long  = upper_limit_check_on
                   && byte_cnt > {{(LEN_W-15){1'b0}}, upper_limit};

    // a buffer error during the frame means it was already counted elsewhere
    // reloading from the pin while idle drops errors between frames, which
    // belong to no frame and must not hold back the next one's count
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            buf_err_seen <= 1'b0;
        end else if (frame_done || state == ST_IDLE) begin
            buf_err_seen <= BUFFER_ERR_IN;
        end else if (BUFFER_ERR_IN) begin
            buf_err_seen <= 1'b1;
        end
    end

    logic viol_short;
    logic viol_long;
    assign viol_short = frame_done && is_short && !buf_err_seen && !BUFFER_ERR_IN;
    assign viol_long  = frame_done && is_long && !buf_err_seen && !BUFFER_ERR_IN;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            FRAME_END_OUT   <= 1'b0;
            FRAME_DROP_OUT  <= 1'b0;
            FRAME_BYTES_OUT <= '0;
        end else begin
            FRAME_END_OUT  <= frame_done;
            FRAME_DROP_OUT <= frame_done && (is_short || is_long);
            if (frame_done) begin
                FRAME_BYTES_OUT <= byte_cnt;
            end
        end
    end

    // =========================================================
    // violation counters, wrap rather than saturate
    logic [SHORT_CNT_W-1:0] short_cnt;
    logic [LONG_CNT_W-1:0]  long_cnt;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            short_cnt <= '0;
        end else if (viol_short) begin
            short_cnt <= short_cnt + 1'b1;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            long_cnt <= '0;
        end else if (viol_long) begin
            long_cnt <= long_cnt + 1'b1;
        end
    end

    // =========================================================
    // AHB-Lite slave, one word per register index
    // transfer size is not decoded: every register is one aligned word
    // and only its low byte is backed by storage
    logic       dp_write;
    logic [9:0] dp_index;
    logic       ap_valid;
    logic [9:0] ap_index;
    logic       wr_event;

    assign ap_valid = HSEL_IN && HREADY_IN
                   && (HTRANS_IN == HTRANS_NONSEQ || HTRANS_IN == HTRANS_SEQ);
    assign ap_index = HADDR_IN[11:2];
    assign wr_event = dp_write && dp_index == IDX_EVENT;

    function automatic logic [7:0] read_reg(input logic [9:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_EVENT:      v = {1'b0, ev_status, 5'h00};
            IDX_MASK:       v = {1'b0, ev_mask, 5'h00};
            IDX_LOWER:      v = {lower_limit_check_on, lower_limit};
            IDX_UPPER_LOW:  v = upper_limit[7:0];
            IDX_UPPER_HIGH: v = {upper_limit_check_on, upper_limit[14:8]};
            IDX_SHORT_B0:   v = short_cnt[7:0];
            IDX_SHORT_B1:   v = short_cnt[15:8];
            IDX_SHORT_B2:   v = short_cnt[23:16];
            IDX_LONG_B0:    v = long_cnt[7:0];
            IDX_LONG_B1:    v = long_cnt[15:8];
            // fixed-zero bytes and unmapped indices fall through here
            default:        v = 8'h00;
        endcase
        return v;
    endfunction

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            dp_write <= 1'b0;
            dp_index <= 10'h000;
        end else begin
            dp_write <= ap_valid && HWRITE_IN;
            dp_index <= ap_index;
        end
    end

    // read data is latched in the address phase so the output is a flop;
    // a counter step in that same cycle shows on the next read
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            if (ap_valid && !HWRITE_IN) begin
                HRDATA_OUT <= {24'h000000, read_reg(ap_index)};
            end
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            lower_limit_check_on <= 1'b0;
            lower_limit          <= LOWER_RESET;
            upper_limit_check_on <= 1'b0;
            upper_limit          <= {UPPER_HI_RESET, UPPER_LOW_RESET};
            ev_mask              <= EV_MASK_RESET;
        end else if (dp_write) begin
            case (dp_index)
                IDX_LOWER: begin
                    lower_limit_check_on <= HWDATA_IN[ENFORCE_BIT];
                    lower_limit          <= HWDATA_IN[6:0];
                end
                IDX_UPPER_LOW: begin
                    upper_limit[7:0] <= HWDATA_IN[7:0];
                end
                IDX_UPPER_HIGH: begin
                    upper_limit_check_on <= HWDATA_IN[ENFORCE_BIT];
                    upper_limit[14:8]    <= HWDATA_IN[6:0];
                end
                IDX_MASK: begin
                    ev_mask <= HWDATA_IN[EV_SHORT_BIT:EV_LONG_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // =========================================================
    // sticky events and interrupt; a new event beats a same-cycle clear
    // the interrupt is a flop, so it trails a status or mask change by a cycle
    logic [1:0] ev_set;
    logic [1:0] ev_clr;
    assign ev_set = {viol_short, viol_long};
    assign ev_clr = wr_event ? HWDATA_IN[EV_SHORT_BIT:EV_LONG_BIT] : 2'h0;

    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            ev_status <= 2'h0;
            IRQ_OUT   <= 1'b0;
        end else begin
            ev_status <= (ev_status & ~ev_clr) | ev_set;
            IRQ_OUT   <= |(ev_status & ~ev_mask);
        end
    end
endmodule

// ===== verification/rx_len_properties.sv
// Purpose: port-level properties of the receive frame length filter
// Assumes: one clock domain, synchronous active-high reset
// Notes:   limits are shadowed from bus writes to judge each discard
`timescale 1ns/1ps
module rx_len_properties
    import rx_len_pkg::*;
(
    input wire logic                         CLOCK_IN,
    input wire logic                         RST_IN,
    input wire logic                         HSEL_IN,
    input wire logic [31:0]                  HADDR_IN,
    input wire logic [1:0]                   HTRANS_IN,
    input wire logic                         HWRITE_IN,
    input wire logic [31:0]                  HWDATA_IN,
    input wire logic                         HREADY_IN,
    input wire logic [31:0]                  HRDATA_OUT,
    input wire logic                         HREADYOUT_OUT,
    input wire logic                         HRESP_OUT,
    input wire logic                         FRAME_END_OUT,
    input wire logic                         FRAME_DROP_OUT,
    input wire logic [rx_len_pkg::LEN_W-1:0] FRAME_BYTES_OUT,
    input wire logic                         IRQ_OUT
);
    logic       ph_wr;
    logic [9:0] ph_idx;
    logic [7:0] lo;
    logic [7:0] hl;
    logic [7:0] hh;
    logic       mask_touched;
    logic       too_short;
    logic       too_long;
    // =========================================================
    // shadow of the limit registers, updated in the data phase
    always_ff @(posedge CLOCK_IN) begin
        if (RST_IN) begin
            ph_wr <= 1'b0;
            ph_idx <= 10'h000;
            lo <= 8'h40;
            hl <= 8'hF2;
            hh <= 8'h05;
            mask_touched <= 1'b0;
        end else if (HREADY_IN) begin
            ph_wr <= HSEL_IN && HTRANS_IN[1] && HWRITE_IN;
            ph_idx <= HADDR_IN[11:2];
            if (ph_wr && ph_idx == IDX_LOWER) lo <= HWDATA_IN[7:0];
            if (ph_wr && ph_idx == IDX_UPPER_LOW) hl <= HWDATA_IN[7:0];
            if (ph_wr && ph_idx == IDX_UPPER_HIGH) hh <= HWDATA_IN[7:0];
            if (ph_wr && ph_idx == IDX_MASK) mask_touched <= 1'b1;
        end
    end
    assign too_short = lo[ENFORCE_BIT] && (FRAME_BYTES_OUT < {9'h000, lo[6:0]});
    assign too_long  = hh[ENFORCE_BIT] && (FRAME_BYTES_OUT > {1'b0, hh[6:0], hl});
    // =========================================================
    // properties
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (RST_IN);
    sequence s_end_pulse;
        FRAME_END_OUT ##1 !FRAME_END_OUT;
    endsequence
    a_ready_high: assert property (HREADYOUT_OUT) else $error("bus wait state seen");
    a_resp_okay: assert property (!HRESP_OUT) else $error("bus error response seen");
    a_rdata_upper_zero: assert property (HRDATA_OUT[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    a_end_one_cycle: assert property (FRAME_END_OUT |-> s_end_pulse)
        else $error("frame end longer than one cycle");
    a_drop_at_end: assert property (FRAME_DROP_OUT |-> FRAME_END_OUT)
        else $error("discard without frame end");
    a_drop_decision: assert property (FRAME_END_OUT |->
        FRAME_DROP_OUT == (too_short || too_long))
        else $error("discard decision disagrees with limits");
    a_bytes_hold: assert property (!FRAME_END_OUT |-> $stable(FRAME_BYTES_OUT))
        else $error("byte count moved between frame ends");
    a_irq_masked_reset: assert property (!mask_touched |-> !IRQ_OUT)
        else $error("interrupt while masks at reset value");
endmodule

// ===== verification/mii_source.sv
// Purpose: link partner sending receive frames nibble by nibble
// Assumes: link clock of 160 ns, data changed on its falling edge
// Notes:   clock stands still between frames; idle data toggles
`timescale 1ns/1ps
module mii_source (
    output logic       rx_clk_out,
    output logic       rx_dv_out,
    output logic [3:0] rxd_out
);
    initial begin
        rx_clk_out = 1'b0;
        rx_dv_out = 1'b0;
        rxd_out = 4'hA;
    end
    // released data shows the inverse so a stale nibble is never trusted
    task automatic nib(input logic dv, input logic [3:0] d);
        rx_dv_out = dv;
        rxd_out = dv ? d : ~rxd_out;
        #80 rx_clk_out = 1'b1;
        #80 rx_clk_out = 1'b0;
    endtask
    task automatic send(input int n);
        // start off the core clock's edges so no pin moves as it is sampled
        #2;
        for (int i = 0; i < 15; i++) nib(1'b1, 4'h5);
        nib(1'b1, 4'hD);
        for (int i = 0; i < 2 * n; i++) nib(1'b1, i[3:0]);
        nib(1'b0, 4'h0);
        nib(1'b0, 4'h0);
    endtask
endmodule

// ===== verification/rx_frame_length_filter_tb.sv
// Purpose: self-checking bench for the receive frame length filter
// Assumes: zero-wait bus slave, limits shrunk to keep frames short
// Notes:   counter wrap is too long to reach here and stays unchecked
`timescale 1ns/1ps
module rx_frame_length_filter_tb;
    import rx_len_pkg::*;
    logic             clk, rst, hsel, hwrite, berr, rx_clk, rx_dv, f_end, f_drop, irq;
    logic             hready, hresp;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [31:0]      haddr, hwdata, hrdata;
    logic [3:0]       rxd;
    logic [LEN_W-1:0] f_bytes;
    int               bad_count = 0;
    int               samples_checked = 0;
    rx_frame_length_filter dut (.CLOCK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .RX_CLK_IN(rx_clk), .RX_DV_IN(rx_dv), .RXD_IN(rxd), .BUFFER_ERR_IN(berr),
        .FRAME_END_OUT(f_end), .FRAME_DROP_OUT(f_drop), .FRAME_BYTES_OUT(f_bytes), .IRQ_OUT(irq));
    mii_source u_src (.rx_clk_out(rx_clk), .rx_dv_out(rx_dv), .rxd_out(rxd));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // =========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wait_ready;
        int k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hready !== 1'b1 && k < 64);
        if (k >= 64) begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d,
                       output logic [31:0] r);
        haddr <= {20'h00000, idx, 2'b00};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        wait_ready();
        r = hrdata;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        bus(idx, 1'b1, d, r);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        logic [31:0] r;
        bus(idx, 1'b0, 8'h00, r);
        check(r, {24'h000000, e});
    endtask
    // sends one frame of n bytes and judges its end pulse
    task automatic frame(input int n, input logic err, input logic drop);
        int k = 0;
        berr <= err;
        fork
            u_src.send(n);
        join_none
        do begin
            @(negedge clk);
            k++;
        end while (f_end !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            bad_count++;
            wrap_up();
        end
        check(32'(f_drop), 32'(drop));
        check(32'(f_bytes), 32'(n));
        wait fork;
        @(posedge clk);
        berr <= 1'b0;
        // let an edge pass so the next frame's error level is a fresh assignment
        @(posedge clk);
    endtask
    // =========================================================
    // scenarios
    task automatic t_reset_vals;
        rd(IDX_LOWER, 8'h40);
        rd(IDX_UPPER_LOW, 8'hF2);
        rd(IDX_UPPER_HIGH, 8'h05);
        rd(IDX_MASK, 8'h60);
        rd(IDX_EVENT, 8'h00);
        rd(10'h1EE, 8'h00);
    endtask
    task automatic t_limits;
        wr(IDX_LOWER, 8'h8A);
        wr(IDX_UPPER_LOW, 8'h14);
        wr(IDX_UPPER_HIGH, 8'h80);
        frame(9, 1'b0, 1'b1);
        frame(10, 1'b0, 1'b0);
        frame(20, 1'b0, 1'b0);
        frame(21, 1'b0, 1'b1);
        frame(9, 1'b1, 1'b1);
        rd(IDX_SHORT_B0, 8'h01);
        rd(IDX_SHORT_B3, 8'h00);
        rd(IDX_LONG_B0, 8'h01);
        rd(IDX_LONG_B2, 8'h00);
        rd(IDX_EVENT, 8'h60);
        check(32'(irq), 32'h0);
        wr(IDX_SHORT_B0, 8'hFF);
        rd(IDX_SHORT_B0, 8'h01);
    endtask
    task automatic t_irq;
        wr(IDX_MASK, 8'h20);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1);
        wr(IDX_EVENT, 8'h40);
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0);
        rd(IDX_EVENT, 8'h20);
    endtask
    task automatic t_checks_off;
        wr(IDX_LOWER, 8'h0A);
        wr(IDX_UPPER_HIGH, 8'h00);
        frame(9, 1'b0, 1'b0);
        frame(21, 1'b0, 1'b0);
        rd(IDX_SHORT_B0, 8'h01);
        rd(IDX_LONG_B0, 8'h01);
    endtask
    task automatic t_reset_clears;
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(IDX_SHORT_B0, 8'h00);
        rd(IDX_LONG_B0, 8'h00);
    endtask
    initial begin
        rst = 1'b1;
        hsel = 1'b1;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        berr = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_vals();
        t_limits();
        t_irq();
        t_checks_off();
        t_reset_clears();
        wrap_up();
    end
endmodule
bind rx_frame_length_filter rx_len_properties u_props (.CLOCK_IN(CLOCK_IN), .RST_IN(RST_IN),
    .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
    .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .FRAME_END_OUT(FRAME_END_OUT),
    .FRAME_DROP_OUT(FRAME_DROP_OUT), .FRAME_BYTES_OUT(FRAME_BYTES_OUT), .IRQ_OUT(IRQ_OUT));
